// ===== core/wpr_pkg.sv
// shared constants for the watchdog and power/reset control block
package wpr_pkg;
    // bus geometry: byte address is four times the register index
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int IDX_W = 8;
    localparam logic [1:0] LANE_OFS = 2'h0;
    localparam logic [1:0] ADDR_TOP_ZERO = 2'h0;
    // register indices
    localparam logic [7:0] IDX_PWR = 8'h87;
    localparam logic [7:0] IDX_AUX = 8'h8E;
    localparam logic [7:0] IDX_WDT = 8'h8F;
    localparam logic [7:0] IDX_STAT = 8'h90;
    localparam logic [7:0] IDX_CNT = 8'h91;
    // power_control fields
    localparam int PWR_POF = 4;
    localparam int PWR_GF1 = 3;
    localparam int PWR_GF0 = 2;
    localparam int PWR_PD = 1;
    localparam int PWR_IDL = 0;
    // auxiliary_control fields
    localparam int AUX_AO = 0;
    // watchdog_control fields
    localparam int WDT_ENW = 7;
    localparam int WDT_WATCHDOG_CLEAR_BIT = 6;
    localparam int WDT_WATCHDOG_IDLE_ENABLE = 5;
    localparam int WDT_PS_HI = 2;
    localparam int WDT_PS_LO = 0;
    // status fields
    localparam int ST_IDLE = 0;
    localparam int ST_PD = 1;
    localparam int ST_CLRP = 2;
    localparam int ST_RST = 3;
    // reset values of special registers
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [7:0] PORT_RST = 8'hFF;
    localparam logic [7:0] SP_RST = 8'h07;
    // watchdog chain widths
    localparam int CNT_W = 14;
    localparam int PRE_W = 8;
    localparam logic [CNT_W-1:0] CNT_MAX = 14'h3FFF;
    // machine cycle: six states of two clocks each
    localparam logic [2:0] STATE_LAST = 3'h5;
    localparam logic [2:0] SAMPLE_STATE = 3'h4;
    // pin must be seen high at this many consecutive samples
    localparam logic [1:0] RST_SAMPLES = 2'h2;
    // bus responses
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;

    // prescaler terminal count (ratio minus one) per select code
    function automatic logic [PRE_W-1:0] ps_limit(input logic [2:0] ps);
        case (ps)
            3'h0: ps_limit = 8'h01;
            3'h2: ps_limit = 8'h03;
            3'h1: ps_limit = 8'h07;
            3'h3: ps_limit = 8'h0F;
            3'h4: ps_limit = 8'h1F;
            3'h5: ps_limit = 8'h3F;
            3'h6: ps_limit = 8'h7F;
            default: ps_limit = 8'hFF;
        endcase
    endfunction : ps_limit
endpackage : wpr_pkg

// ===== core/wpr_top.sv
// watchdog, power modes, reset sampling and strobe suppression
//
// Contract
// - with strobe-off bit set, stop address strobe during internal code execution
// - while suppressed, still pass strobe for external accesses or external code
// - power-off flag set by power-on reset, software clears, other resets keep it
// - two user flag bits, read/write, no side effect
// - idle bit gates core clock, peripherals and interrupts keep clocking
// - enabled interrupt request or reset ends idle, core clock returns
// - power-down bit stops every clock including the oscillator
// - only a reset ends power-down; interrupts do not wake it
// - watchdog is a free divider; enabled time-out forces system reset
// - any reset disables the watchdog and clears its counter
// - enable bit lets watchdog count; cleared, it never resets
// - clear bit write resets counter, prescaler, itself at next machine cycle
// - watchdog runs in idle only if idle-enable set; default clear
// - three select bits choose prescaler ratio 2 up to 256
// - time-out equals osc period times 2^14 times ratio times twelve
// - oscillator divided by two before internal use
// - reset pin sampled at state five phase two; two machine cycles needed
// - reset pin path filters short glitches
// - reset puts ports FFH, stack 07H, other special registers 00H
`timescale 1ns/10ps
module wpr_top (
    // clock and power-on reset
    input wire logic clock,
    input wire logic sys_rst,
    // AXI4-Lite write address and data
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // external reset pin and interrupt logic
    input wire logic resetPin,
    input wire logic intReq,
    // core strobe and fetch context
    input wire logic strobeIn,
    input wire logic codeInternal,
    input wire logic extAccess,
    // outputs to the rest of the chip
    output logic strobeOut,
    output logic coreClkEn,
    output logic periphClkEn,
    output logic oscEn,
    output logic chipReset
);

    // index of a byte address, or an out-of-range marker
    function automatic logic [8:0] reg_index(input logic [11:0] a);
        if (a[1:0] != wpr_pkg::LANE_OFS || a[11:10] != wpr_pkg::ADDR_TOP_ZERO) begin
            reg_index = {1'b1, 8'h00};
        end else begin
            reg_index = {1'b0, a[9:2]};
        end
    endfunction : reg_index

    // registers
    logic powerOffFlag;
    logic userFlagOne;
    logic userFlagZero;
    logic powerDownBit;
    logic idleBit;
    logic strobeOffBit;
    logic watchdogEnableBit;
    logic watchdogClearBit;
    logic watchdogIdleEnable;
    logic [2:0] prescaleSel;

    // machine cycle timing
    logic halfPhase;
    logic [2:0] stateCnt;
    logic sampleTick;
    logic machineTick;

    // reset pin path
    logic pinSync1;
    logic pinSync2;
    logic pinSync3;
    logic pinLevel;
    logic [1:0] pinCount;

    // watchdog chain
    logic [wpr_pkg::PRE_W-1:0] preCnt;
    logic [wpr_pkg::CNT_W-1:0] wdtCnt;
    logic wdtRun;
    logic preTerm;
    logic timeOut;

    // bus slave state
    logic awHeld;
    logic wHeld;
    logic [11:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic doWrite;
    logic [8:0] wIdx;
    logic wLane0;
    logic [8:0] rIdx;

    // modes, power-down taking precedence over idle
    logic idleActive;
    logic pdActive;
    assign pdActive = powerDownBit;
    assign idleActive = idleBit & ~powerDownBit;

    // clock-enable halving, so every state spans two clocks
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            halfPhase <= 1'b0;
        end else begin
            halfPhase <= ~halfPhase;
        end
    end

    // state counter inside the machine cycle
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            stateCnt <= 3'h0;
        end else if (halfPhase) begin
            if (stateCnt == wpr_pkg::STATE_LAST) begin
                stateCnt <= 3'h0;
            end else begin
                stateCnt <= stateCnt + 3'h1;
            end
        end
    end

    // one machine cycle is twelve clocks
    assign sampleTick = halfPhase && stateCnt == wpr_pkg::SAMPLE_STATE;
    assign machineTick = halfPhase && stateCnt == wpr_pkg::STATE_LAST;

    // three-stage pin synchroniser
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pinSync1 <= 1'b0;
            pinSync2 <= 1'b0;
            pinSync3 <= 1'b0;
        end else begin
            pinSync1 <= resetPin;
            pinSync2 <= pinSync1;
            pinSync3 <= pinSync2;
        end
    end

    // level only moves once stages two and three agree
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pinLevel <= 1'b0;
        end else if (pinSync2 == pinSync3) begin
            pinLevel <= pinSync3;
        end
    end

    // consecutive high samples; one low sample restarts the count
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pinCount <= 2'h0;
        end else if (sampleTick) begin
            if (!pinLevel) begin
                pinCount <= 2'h0;
            end else if (pinCount != wpr_pkg::RST_SAMPLES) begin
                pinCount <= pinCount + 2'h1;
            end
        end
    end

    // internal reset: pin held long enough, or watchdog time-out
    // a time-out holds it to the end of the next machine cycle
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            chipReset <= 1'b0;
        end else if (timeOut) begin
            chipReset <= 1'b1;
        end else if (sampleTick && pinLevel && pinCount == wpr_pkg::RST_SAMPLES - 2'h1) begin
            chipReset <= 1'b1;
        end else if (machineTick && pinCount != wpr_pkg::RST_SAMPLES) begin
            chipReset <= 1'b0;
        end
    end

    // watchdog counts only while enabled and not halted by a mode
    assign wdtRun = watchdogEnableBit && !pdActive && (!idleActive || watchdogIdleEnable);
    assign preTerm = preCnt == wpr_pkg::ps_limit(prescaleSel);
    assign timeOut = wdtRun && machineTick && preTerm && wdtCnt == wpr_pkg::CNT_MAX;

    // prescaler stepped per machine cycle, then 14-bit divider once per prescaler wrap
    always_ff @(posedge clock) begin
        if (sys_rst || chipReset) begin
            preCnt <= '0;
            wdtCnt <= '0;
        end else if (machineTick && watchdogClearBit) begin
            preCnt <= '0;
            wdtCnt <= '0;
        end else if (machineTick && wdtRun) begin
            if (preTerm) begin
                preCnt <= '0;
                wdtCnt <= wdtCnt + 14'h0001;
            end else begin
                preCnt <= preCnt + 8'h01;
            end
        end
    end

    // write decode shared by all register processes
    assign doWrite = awHeld && wHeld && !s_axi_bvalid;
    assign wIdx = reg_index(awAddr);
    assign wLane0 = wStrb[0];

    // power-off flag: power-on reset sets it, a write loads it, chip reset leaves it
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            powerOffFlag <= 1'b1;
        end else if (doWrite && wLane0 && wIdx == {1'b0, wpr_pkg::IDX_PWR}) begin
            powerOffFlag <= wData[wpr_pkg::PWR_POF];
        end
    end

    // user flags and power mode bits
    always_ff @(posedge clock) begin
        if (sys_rst || chipReset) begin
            userFlagOne <= 1'b0;
            userFlagZero <= 1'b0;
            powerDownBit <= 1'b0;
            idleBit <= 1'b0;
        end else begin
            if (doWrite && wLane0 && wIdx == {1'b0, wpr_pkg::IDX_PWR}) begin
                userFlagOne <= wData[wpr_pkg::PWR_GF1];
                userFlagZero <= wData[wpr_pkg::PWR_GF0];
                powerDownBit <= wData[wpr_pkg::PWR_PD];
                idleBit <= wData[wpr_pkg::PWR_IDL];
            end else if (intReq && idleActive) begin
                idleBit <= 1'b0;
            end
        end
    end

    // auxiliary control
    always_ff @(posedge clock) begin
        if (sys_rst || chipReset) begin
            strobeOffBit <= 1'b0;
        end else if (doWrite && wLane0 && wIdx == {1'b0, wpr_pkg::IDX_AUX}) begin
            strobeOffBit <= wData[wpr_pkg::AUX_AO];
        end
    end

    // watchdog control; a new write of the clear bit beats the self-clear
    always_ff @(posedge clock) begin
        if (sys_rst || chipReset) begin
            watchdogEnableBit <= 1'b0;
            watchdogClearBit <= 1'b0;
            watchdogIdleEnable <= 1'b0;
            prescaleSel <= 3'h0;
        end else if (doWrite && wLane0 && wIdx == {1'b0, wpr_pkg::IDX_WDT}) begin
            watchdogEnableBit <= wData[wpr_pkg::WDT_ENW];
            watchdogClearBit <= wData[wpr_pkg::WDT_WATCHDOG_CLEAR_BIT] | (watchdogClearBit & ~machineTick);
            watchdogIdleEnable <= wData[wpr_pkg::WDT_WATCHDOG_IDLE_ENABLE];
            prescaleSel <= wData[wpr_pkg::WDT_PS_HI:wpr_pkg::WDT_PS_LO];
        end else if (machineTick) begin
            watchdogClearBit <= 1'b0;
        end
    end

    // clock gates; oscillator and peripherals stop only in power-down
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            coreClkEn <= 1'b1;
            periphClkEn <= 1'b1;
            oscEn <= 1'b1;
        end else begin
            coreClkEn <= !idleActive && !pdActive && !chipReset;
            periphClkEn <= !pdActive;
            oscEn <= !pdActive;
        end
    end

    // strobe passes during external work, muted on internal fetches
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            strobeOut <= 1'b0;
        end else if (strobeOffBit && codeInternal && !extAccess) begin
            strobeOut <= 1'b0;
        end else begin
            strobeOut <= strobeIn;
        end
    end

    // write address channel, held until the response is taken
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            awHeld <= 1'b0;
            awAddr <= 12'h000;
            s_axi_awready <= 1'b0;
        end else if (!awHeld && !s_axi_awready) begin
            s_axi_awready <= 1'b1;
        end else if (s_axi_awready && s_axi_awvalid) begin
            awHeld <= 1'b1;
            awAddr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            awHeld <= 1'b0;
        end
    end

    // write data channel, taken independently of the address
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wHeld <= 1'b0;
            wData <= 32'h00000000;
            wStrb <= 4'h0;
            s_axi_wready <= 1'b0;
        end else if (!wHeld && !s_axi_wready) begin
            s_axi_wready <= 1'b1;
        end else if (s_axi_wready && s_axi_wvalid) begin
            wHeld <= 1'b1;
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            wHeld <= 1'b0;
        end
    end

    // write response; unmapped and read-only indices answer with an error
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= wpr_pkg::RESP_OK;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            if (wIdx == {1'b0, wpr_pkg::IDX_PWR} || wIdx == {1'b0, wpr_pkg::IDX_AUX}
                || wIdx == {1'b0, wpr_pkg::IDX_WDT}) begin
                s_axi_bresp <= wpr_pkg::RESP_OK;
            end else begin
                s_axi_bresp <= wpr_pkg::RESP_ERR;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // read channel: accept when idle, answer the next cycle
    assign rIdx = reg_index(s_axi_araddr);
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= wpr_pkg::RESP_OK;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else if (!s_axi_arready) begin
            s_axi_arready <= 1'b1;
        end else if (s_axi_arvalid) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= wpr_pkg::RESP_OK;
            s_axi_rdata <= 32'h00000000;
            if (rIdx == {1'b0, wpr_pkg::IDX_PWR}) begin
                s_axi_rdata[wpr_pkg::PWR_POF] <= powerOffFlag;
                s_axi_rdata[wpr_pkg::PWR_GF1] <= userFlagOne;
                s_axi_rdata[wpr_pkg::PWR_GF0] <= userFlagZero;
                s_axi_rdata[wpr_pkg::PWR_PD] <= powerDownBit;
                s_axi_rdata[wpr_pkg::PWR_IDL] <= idleBit;
            end else if (rIdx == {1'b0, wpr_pkg::IDX_AUX}) begin
                s_axi_rdata[wpr_pkg::AUX_AO] <= strobeOffBit;
            end else if (rIdx == {1'b0, wpr_pkg::IDX_WDT}) begin
                s_axi_rdata[wpr_pkg::WDT_ENW] <= watchdogEnableBit;
                s_axi_rdata[wpr_pkg::WDT_WATCHDOG_CLEAR_BIT] <= watchdogClearBit;
                s_axi_rdata[wpr_pkg::WDT_WATCHDOG_IDLE_ENABLE] <= watchdogIdleEnable;
                s_axi_rdata[wpr_pkg::WDT_PS_HI:wpr_pkg::WDT_PS_LO] <= prescaleSel;
            end else if (rIdx == {1'b0, wpr_pkg::IDX_STAT}) begin
                s_axi_rdata[wpr_pkg::ST_IDLE] <= idleActive;
                s_axi_rdata[wpr_pkg::ST_PD] <= pdActive;
                s_axi_rdata[wpr_pkg::ST_CLRP] <= watchdogClearBit;
                s_axi_rdata[wpr_pkg::ST_RST] <= chipReset;
            end else if (rIdx == {1'b0, wpr_pkg::IDX_CNT}) begin
                s_axi_rdata[wpr_pkg::CNT_W-1:0] <= wdtCnt;
            end else begin
                s_axi_rresp <= wpr_pkg::RESP_ERR;
            end
        end
    end

endmodule : wpr_top

// ===== testbench/wpr_core_model.sv
// behavioural core and interrupt source facing the block
`timescale 1ns/10ps
module wpr_core_model (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // bench controls
    input wire logic extMode,
    input wire logic wakeReq,
    // pins into the block
    output logic strobeIn,
    output logic codeInternal,
    output logic extAccess,
    output logic intReq
);
    logic [2:0] reqLeft = 3'h0;
    // strobe runs freely, as a busy core emits it
    always @(posedge clock) begin
        strobeIn <= !sys_rst && !strobeIn;
    end
    // external mode: code and data both outside
    assign codeInternal = !extMode;
    assign extAccess = extMode;
    // request held six clocks, as a waiting source
    always @(posedge clock) begin
        if (sys_rst) reqLeft <= 3'h0;
        else if (wakeReq && reqLeft == 3'h0) reqLeft <= 3'h6;
        else if (reqLeft != 3'h0) reqLeft <= reqLeft - 3'h1;
    end
    assign intReq = (reqLeft != 3'h0);
endmodule : wpr_core_model

// ===== testbench/wpr_top_chk.sv
// pin-level assertions for the watchdog and power/reset block
`timescale 1ns/10ps
module wpr_top_chk (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // pin side inputs
    input wire logic resetPin,
    input wire logic intReq,
    input wire logic strobeIn,
    input wire logic codeInternal,
    input wire logic extAccess,
    // block outputs
    input wire logic strobeOut,
    input wire logic coreClkEn,
    input wire logic periphClkEn,
    input wire logic oscEn,
    input wire logic chipReset
);
    logic [5:0] pinHigh;
    logic [5:0] pinLow;
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    // saturating run lengths of the pin level
    always_ff @(posedge clock) begin
        if (sys_rst || !resetPin) pinHigh <= 6'h00;
        else if (pinHigh != 6'h3F) pinHigh <= pinHigh + 6'h01;
    end
    always_ff @(posedge clock) begin
        if (sys_rst || resetPin) pinLow <= 6'h00;
        else if (pinLow != 6'h3F) pinLow <= pinLow + 6'h01;
    end
    AST_STROBE_PASS: assert property (
        !$past(sys_rst) && !$past(chipReset) && (!$past(codeInternal) || $past(extAccess))
        |-> strobeOut == $past(strobeIn)) else $error("strobe not passed");
    AST_PERIPH_RUNS: assert property (
        periphClkEn == oscEn) else $error("peripheral clock off");
    AST_PD_CLOCKS: assert property (
        !oscEn && !$past(oscEn) |-> !coreClkEn) else $error("core clock in power-down");
    AST_IDLE_WAKE: assert property (
        intReq && oscEn && !coreClkEn && !chipReset |-> ##[1:4] coreClkEn) else $error("idle not left");
    AST_RST_RESUMES: assert property (
        $fell(chipReset) |-> ##[0:3] (coreClkEn && oscEn)) else $error("clocks not back");
    AST_PD_EXIT: assert property (
        $rose(oscEn) |-> $past(sys_rst) || $past(chipReset) || $past(chipReset, 2) || $past(chipReset, 3))
        else $error("power-down left");
    AST_RST_FILTER: assert property (
        !chipReset && pinLow > 6'd30 ##1 resetPin ##1 !resetPin |=> !chipReset [*8])
        else $error("glitch caused a reset");
    AST_RST_HOLD: assert property (
        pinHigh > 6'd30 |-> chipReset) else $error("held pin gave no reset");
    AST_RST_RELEASE: assert property (
        pinLow == 6'd40 |-> !chipReset) else $error("reset outlasts pin");
    COV_IDLE: cover property ($fell(coreClkEn) && oscEn);
    COV_PD: cover property ($fell(oscEn));
    COV_PIN_RST: cover property ($rose(chipReset) && resetPin);
endmodule : wpr_top_chk

bind wpr_top wpr_top_chk u_wpr_top_chk (
    .clock(clock), .sys_rst(sys_rst), .resetPin(resetPin), .intReq(intReq),
    .strobeIn(strobeIn), .codeInternal(codeInternal), .extAccess(extAccess),
    .strobeOut(strobeOut), .coreClkEn(coreClkEn), .periphClkEn(periphClkEn),
    .oscEn(oscEn), .chipReset(chipReset)
);

// ===== testbench/tb_top.sv
// self-checking bench for the watchdog and power/reset block
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
    $display("unexpected %s: expected %h seen %h", nm, e, g); end end
module tb_top;
    localparam logic [7:0] PWR = wpr_pkg::IDX_PWR, AUX = wpr_pkg::IDX_AUX, WDT = wpr_pkg::IDX_WDT;
    localparam logic [7:0] STA = wpr_pkg::IDX_STAT, CNT = wpr_pkg::IDX_CNT;
    localparam logic [1:0] OK = wpr_pkg::RESP_OK, ER = wpr_pkg::RESP_ERR;
    localparam logic [31:0] ALL = 32'hFFFFFFFF;
    logic clock = 1'b0, sys_rst = 1'b1, resetPin = 1'b0, extMode = 1'b0, wakeReq = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b1, rready = 1'b1;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0, rdata, got, c1, r, mask;
    logic [3:0] wstrb = 4'h0;
    logic [1:0] bresp, rresp, expB;
    logic [33:0] expR;
    logic [4:0] hits;
    logic awready, wready, bvalid, arready, rvalid, strobeIn, codeInternal, extAccess, intReq;
    logic strobeOut, coreClkEn, periphClkEn, oscEn, chipReset;
    logic [1:0] bq[$];
    logic [33:0] rq[$];
    logic [31:0] mq[$];
    int bad_count = 0, n_tests = 0, seed = 32'h9A84141F;
    always #2 clock = ~clock;
    wpr_top u_wpr_top (.clock(clock), .sys_rst(sys_rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .resetPin(resetPin), .intReq(intReq), .strobeIn(strobeIn), .codeInternal(codeInternal),
        .extAccess(extAccess), .strobeOut(strobeOut), .coreClkEn(coreClkEn),
        .periphClkEn(periphClkEn), .oscEn(oscEn), .chipReset(chipReset));
    wpr_core_model u_wpr_core_model (.clock(clock), .sys_rst(sys_rst), .extMode(extMode),
        .wakeReq(wakeReq), .strobeIn(strobeIn), .codeInternal(codeInternal),
        .extAccess(extAccess), .intReq(intReq));
    // oldest note against each answer the slave hands over
    always @(posedge clock) begin
        if (bvalid && bready) begin
            expB = bq.pop_front();
            `CHK("write response", expB, bresp)
        end
        if (rvalid && rready) begin
            expR = rq.pop_front();
            mask = mq.pop_front();
            `CHK("read word", expR, {rresp, rdata & mask})
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask : cyc
    // bready stays high, so a write ends at the response edge
    task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [3:0] st, input logic [1:0] rsp);
        bq.push_back(rsp);
        awaddr <= {2'h0, idx, 2'h0};
        wdata <= d;
        wstrb <= st;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge clock);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!(bvalid && bready));
    endtask : wr
    // mask zero: caller judges the value
    task automatic rd(input logic [7:0] idx, input logic [31:0] e, input logic [31:0] m, input logic [1:0] rsp,
                      output logic [31:0] v);
        rq.push_back({rsp, e & m});
        mq.push_back(m);
        araddr <= {2'h0, idx, 2'h0};
        arvalid <= 1'b1;
        do begin
            @(posedge clock);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!(rvalid && rready));
        v = rdata;
    endtask : rd
    task automatic wake;
        wakeReq <= 1'b1;
        cyc(1);
        wakeReq <= 1'b0;
    endtask : wake
    localparam logic [7:0][8:0] RAT = {9'h100, 9'h080, 9'h040, 9'h020, 9'h010, 9'h004, 9'h008, 9'h002};
    task automatic end_test(input string nm);
        $display("test %s done, %0d mismatches", nm, bad_count);
    endtask : end_test
    task automatic stop_test;
        $display("checks %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test
    // a hang costs a mismatch; normal run is near 62.5k clocks
    initial begin
        cyc(90000);
        bad_count++;
        $display("unexpected timeout: expected end seen hang");
        stop_test();
    end
    initial begin
        cyc(16);
        sys_rst <= 1'b0;
        cyc(2);
        rd(PWR, 32'h10, ALL, OK, got);
        rd(AUX, 32'h0, ALL, OK, got);
        rd(WDT, 32'h0, ALL, OK, got);
        rd(CNT, 32'h0, ALL, OK, got);
        rd(8'h00, 32'h0, ALL, ER, got);
        wr(CNT, 32'h1, 4'hF, ER);
        end_test("reset values");
        for (int i = 0; i < 4; i++) begin
            r = $random(seed);
            wr(PWR, {r[31:8], 4'h0, r[3:2], 2'h0}, 4'hF, OK);
            rd(PWR, {28'h0, r[3:2], 2'h0}, ALL, OK, got);
            `CHK("core clock", 1'b1, coreClkEn)
        end
        wr(PWR, 32'h0, 4'h1, OK);
        wr(AUX, 32'h1, 4'h0, OK);
        rd(AUX, 32'h0, ALL, OK, got);
        end_test("user flags");
        wr(AUX, 32'h1, 4'h1, OK);
        // internal, external, then internal again
        for (int m = 0; m < 3; m++) begin
            extMode <= (m == 1);
            cyc(3);
            hits = 5'h00;
            repeat (16) begin
                @(posedge clock);
                hits = hits + {4'h0, strobeOut};
            end
            `CHK("strobe count", (m == 1) ? 5'h08 : 5'h00, hits)
        end
        extMode <= 1'b0;
        end_test("strobe");
        wr(WDT, 32'hC0, 4'h1, OK);
        wr(PWR, 32'h1, 4'h1, OK);
        cyc(3);
        `CHK("core clock", 1'b0, coreClkEn)
        `CHK("periph clock", 1'b1, periphClkEn)
        rd(STA, 32'h1, 32'h3, OK, got);
        rd(CNT, 32'h0, 32'h0, OK, c1);
        cyc(240);
        rd(CNT, 32'h0, 32'h0, OK, got);
        `CHK("idle count", c1, got)
        wake();
        cyc(8);
        `CHK("core clock", 1'b1, coreClkEn)
        rd(PWR, 32'h0, 32'h3, OK, got);
        end_test("idle");
        // ten counter steps per select code, within one step
        for (int p = 0; p < 8; p++) begin
            wr(WDT, {24'h0, 5'h18, p[2:0]}, 4'h1, OK);
            cyc(120 * RAT[p]);
            rd(CNT, 32'h0, 32'h0, OK, got);
            `CHK("count in range", 1'b1, (got >= 32'd9 && got <= 32'd11))
        end
        wr(WDT, 32'hC7, 4'h1, OK);
        cyc(20);
        rd(CNT, 32'h0, ALL, OK, got);
        rd(WDT, 32'h87, ALL, OK, got);
        wr(WDT, 32'h00, 4'h1, OK);
        cyc(600);
        rd(CNT, 32'h0, ALL, OK, got);
        end_test("watchdog");
        wr(WDT, 32'hA5, 4'h1, OK);
        wr(PWR, 32'h3, 4'h1, OK);
        cyc(3);
        `CHK("oscillator", 1'b0, oscEn)
        `CHK("periph clock", 1'b0, periphClkEn)
        wake();
        cyc(20);
        `CHK("oscillator", 1'b0, oscEn)
        rd(STA, 32'h2, 32'h3, OK, got);
        // one-clock and six-clock glitches must not reset
        for (int g = 1; g < 7; g += 5) begin
            resetPin <= 1'b1;
            cyc(g);
            resetPin <= 1'b0;
            cyc(40);
            `CHK("oscillator", 1'b0, oscEn)
        end
        resetPin <= 1'b1;
        cyc(40);
        `CHK("system reset", 1'b1, chipReset)
        resetPin <= 1'b0;
        cyc(40);
        `CHK("system reset", 1'b0, chipReset)
        `CHK("oscillator", 1'b1, oscEn)
        rd(PWR, 32'h0, ALL, OK, got);
        rd(AUX, 32'h0, ALL, OK, got);
        rd(WDT, 32'h0, ALL, OK, got);
        rd(CNT, 32'h0, ALL, OK, got);
        end_test("power-down and pin reset");
        sys_rst <= 1'b1;
        cyc(4);
        sys_rst <= 1'b0;
        cyc(2);
        rd(PWR, 32'h10, ALL, OK, got);
        end_test("power-on again");
        stop_test();
    end
endmodule : tb_top
